// [pkg/trig_seq_pkg.sv]
// Shared constants and types for the state trigger sequencer.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package trig_seq_pkg;

    localparam int LABEL_W = 16;
    localparam int NUM_PAT = 8;
    localparam int GRP_W = 4;
    localparam int NUM_LVL = 8;
    localparam int LVL_W = 3;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RANGE_LO = 8'h08;
    localparam logic [7:0] OFF_RANGE_HI = 8'h0c;
    localparam logic [7:0] OFF_GATE = 8'h10;
    localparam logic [7:0] OFF_CMD = 8'h14;
    localparam logic [7:0] OFF_LEVELS = 8'h18;
    localparam logic [7:0] OFF_PAT_BASE = 8'h20;
    localparam logic [7:0] OFF_LVL_BASE = 8'h40;

    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_DUAL_BIT = 1;
    localparam int CTRL_SECOND_BIT = 2;
    localparam int ST_LVL_LSB = 0;
    localparam int ST_TRIG_BIT = 3;
    localparam int ST_LAST_BIT = 4;
    localparam int ST_RUN_BIT = 5;
    localparam int GATE_G1_SEL_LSB = 0;
    localparam int GATE_G2_SEL_LSB = 4;
    localparam int GATE_G1_AND_BIT = 8;
    localparam int GATE_G2_AND_BIT = 9;
    localparam int GATE_RANGE_LSB = 10;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_AT_LSB = 4;
    localparam int LEVELS_NUM_LSB = 0;
    localparam int LEVELS_TRIG_LSB = 8;

    // Qualifier codes; pattern codes are base plus recognizer index
    localparam logic [4:0] Q_ANY = 5'h00;
    localparam logic [4:0] Q_NONE = 5'h01;
    localparam logic [4:0] Q_PAT = 5'h02;
    localparam logic [4:0] Q_NPAT = 5'h0a;
    localparam logic [4:0] Q_RANGE = 5'h12;
    localparam logic [4:0] Q_NRANGE = 5'h13;
    localparam logic [4:0] Q_COMB = 5'h14;

    localparam logic [1:0] CMD_INS_BEFORE = 2'h1;
    localparam logic [1:0] CMD_INS_AFTER = 2'h2;
    localparam logic [1:0] CMD_DELETE = 2'h3;

    typedef enum logic [1:0] {RNG_OFF, RNG_IN, RNG_OUT} range_mode_t;

    typedef struct packed {
        logic [15:0] care;
        logic [15:0] value;
    } pattern_cfg_t;

    typedef struct packed {
        logic [15:0] occ;
        logic [2:0] rsv1;
        logic [4:0] branch_q;
        logic [2:0] rsv0;
        logic [4:0] store_q;
    } level_cfg_t;

    typedef struct packed {
        logic valid;
        logic [LABEL_W-1:0] data;
    } sample_t;

    localparam logic [3:0] NUM_LVL_MIN = 4'h2;
    localparam logic [3:0] NUM_LVL_MAX = 4'h8;
    localparam logic [3:0] NUM_LVL_RST = 4'h2;
    localparam logic [2:0] TRIG_LVL_RST = 3'h0;
    localparam pattern_cfg_t PAT_RST = 32'h0000_0000;
    localparam level_cfg_t LVL_TRIG_DEFAULT = '{16'h0001, 3'h0, Q_PAT, 3'h0, Q_ANY};
    localparam level_cfg_t LVL_STORE_DEFAULT = '{16'h0001, 3'h0, Q_NONE, 3'h0, Q_ANY};
    localparam level_cfg_t LVL_NEW_DEFAULT = '{16'h0001, 3'h0, Q_ANY, 3'h0, Q_ANY};

endpackage

// [hw/pattern_recognizer.sv]
// One three-valued pattern recognizer for a single label.
// Assumes the label value is already sampled on the state clock.
`timescale 1ns/1ps
module pattern_recognizer
    import trig_seq_pkg::*;
(
    input trig_seq_pkg::pattern_cfg_t cfg_i,
    input wire logic [trig_seq_pkg::LABEL_W-1:0] data_i,
    output logic match_o
);
    // Care bit low means don't care for that bit
    assign match_o = &(~cfg_i.care | ~(data_i ^ cfg_i.value));
endmodule

// [hw/state_trigger_sequencer.sv]
// Trigger qualification and level sequencer for a state analyzer.
// Assumes samples arrive synchronous to clk_i with a valid strobe,
// and software configures it over classic Wishbone.
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - Recognizer matches all cared bits, three-valued
// - Eight recognizers single, four each when dual
// - Recognizers a-h in groups a-d, e-h
// - Dual: first owns a-d and range
// - Range hit inclusive between lower and upper
// - One range recognizer, owned by first analyzer
// - Qualifier: any, none, pattern, range, negations, combination
// - One operator per group; OR true, AND negated
// - AND gate inverts its pattern inputs, not the range input
// - Per-input select; only selected inputs count
// - Range feeds only the first group gate
// - Range input: off, in, or out
// - Dual: combination uses own group gate only
// - Two to eight active levels
// - Trigger level within first seven levels
// - Insert before or after; none at eight
// - Per-level storage qualifier gates stored states
// - Advance after occurrence count, 1 to 65535
// - Trigger and final levels reset, not removed
module state_trigger_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input trig_seq_pkg::sample_t sample_i,
    output logic store_o,
    output logic [trig_seq_pkg::LABEL_W-1:0] store_data_o,
    output logic trigger_o,
    output logic [trig_seq_pkg::LVL_W-1:0] level_o,
    output logic running_o
);
    import trig_seq_pkg::*;

    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;

    logic dual_mode;
    logic second_owner;
    logic [LABEL_W-1:0] range_lo;
    logic [LABEL_W-1:0] range_hi;
    logic [GRP_W-1:0] g1_sel;
    logic [GRP_W-1:0] g2_sel;
    logic g1_and;
    logic g2_and;
    range_mode_t range_mode;
    logic [3:0] num_lvl;
    logic [LVL_W-1:0] trig_lvl;
    pattern_cfg_t pat_cfg [NUM_PAT];
    level_cfg_t lvl_cfg [NUM_LVL];
    seq_state_t seq_state;
    logic [LVL_W-1:0] cur_lvl;
    logic [15:0] occ_cnt;
    logic triggered;

    logic wb_req;
    logic wb_wr;
    logic [NUM_PAT-1:0] pat_hit;
    logic [NUM_PAT-1:0] avail;
    logic range_hit;
    logic range_ok;
    logic g1;
    logic g2;
    logic comb;
    logic [LVL_W-1:0] last_lvl;
    level_cfg_t cur_cfg;
    logic store_hit;
    logic branch_hit;
    logic advance;
    logic [31:0] rd_data;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic in_bank(input logic [7:0] adr, input logic [7:0] base);
        return adr[7:5] == base[7:5];
    endfunction

    // Unavailable recognizers read false in both polarities
    function automatic logic qual_eval(input logic [4:0] q, input logic [NUM_PAT-1:0] pm,
                                       input logic [NUM_PAT-1:0] av, input logic rng,
                                       input logic rok, input logic cmb);
        logic [4:0] d;
        logic r;
        d = 5'h00;
        r = 1'b0;
        if (q == Q_ANY) begin
            r = 1'b1;
        end else if (q >= Q_PAT && q < Q_NPAT) begin
            d = q - Q_PAT;
            r = pm[d[2:0]] & av[d[2:0]];
        end else if (q >= Q_NPAT && q < Q_RANGE) begin
            d = q - Q_NPAT;
            r = ~pm[d[2:0]] & av[d[2:0]];
        end else if (q == Q_RANGE) begin
            r = rng & rok;
        end else if (q == Q_NRANGE) begin
            r = ~rng & rok;
        end else if (q == Q_COMB) begin
            r = cmb;
        end
        return r;
    endfunction

    function automatic logic [3:0] clamp_num(input logic [3:0] n);
        logic [3:0] r;
        r = n;
        if (n < NUM_LVL_MIN) begin
            r = NUM_LVL_MIN;
        end else if (n > NUM_LVL_MAX) begin
            r = NUM_LVL_MAX;
        end
        return r;
    endfunction

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i;

    // Recognizers a-d form the first group, e-h the second
    for (genvar i = 0; i < NUM_PAT; i++) begin : g_pat
        pattern_recognizer u_pat (
            .cfg_i(pat_cfg[i]),
            .data_i(sample_i.data),
            .match_o(pat_hit[i])
        );
    end

    always_comb begin
        avail = 8'hff;
        if (dual_mode) begin
            avail = second_owner ? 8'hf0 : 8'h0f;
        end
    end

    assign range_hit = (sample_i.data >= range_lo) && (sample_i.data <= range_hi);
    assign range_ok = ~(dual_mode & second_owner);

    always_comb begin
        logic [GRP_W-1:0] in1;
        logic [GRP_W-1:0] in2;
        logic [GRP_W-1:0] use1;
        logic [GRP_W-1:0] use2;
        logic rterm;
        logic ruse;
        in1 = g1_and ? ~pat_hit[GRP_W-1:0] : pat_hit[GRP_W-1:0];
        in2 = g2_and ? ~pat_hit[NUM_PAT-1:GRP_W] : pat_hit[NUM_PAT-1:GRP_W];
        use1 = g1_sel & avail[GRP_W-1:0];
        use2 = g2_sel & avail[NUM_PAT-1:GRP_W];
        rterm = (range_mode == RNG_OUT) ? ~range_hit : range_hit;
        ruse = (range_mode != RNG_OFF) && range_ok;
        // Range joins group one only; an empty gate reads false
        if (g1_and) begin
            g1 = ((|use1) | ruse) & (&(in1 | ~use1)) & (rterm | ~ruse);
        end else begin
            g1 = (|(in1 & use1)) | (rterm & ruse);
        end
        if (g2_and) begin
            g2 = (|use2) & (&(in2 | ~use2));
        end else begin
            g2 = |(in2 & use2);
        end
        if (dual_mode) begin
            comb = second_owner ? g2 : g1;
        end else begin
            comb = g1 | g2;
        end
    end

    assign last_lvl = 3'(num_lvl - 4'h1);
    assign cur_cfg = lvl_cfg[cur_lvl];

    always_comb begin
        store_hit = qual_eval(cur_cfg.store_q, pat_hit, avail, range_hit, range_ok,
                              comb);
        branch_hit = qual_eval(cur_cfg.branch_q, pat_hit, avail, range_hit, range_ok,
                               comb);
        // The final level has no primary branch
        advance = (seq_state == SEQ_RUN) && sample_i.valid && (cur_lvl < last_lvl)
                  && branch_hit && (occ_cnt == cur_cfg.occ - 16'h1);
    end

    // Control, gate and range registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dual_mode <= 1'b0;
            second_owner <= 1'b0;
            range_lo <= '0;
            range_hi <= '0;
            g1_sel <= '0;
            g2_sel <= '0;
            g1_and <= 1'b0;
            g2_and <= 1'b0;
            range_mode <= RNG_OFF;
        end else if (wb_wr) begin
            if (wb_adr_i == OFF_CTRL && wb_sel_i[0]) begin
                dual_mode <= wb_dat_i[CTRL_DUAL_BIT];
                second_owner <= wb_dat_i[CTRL_SECOND_BIT];
            end
            if (wb_adr_i == OFF_RANGE_LO) begin
                range_lo <= LABEL_W'(merge({16'h0000, range_lo}, wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == OFF_RANGE_HI) begin
                range_hi <= LABEL_W'(merge({16'h0000, range_hi}, wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == OFF_GATE) begin
                if (wb_sel_i[0]) begin
                    g1_sel <= wb_dat_i[GATE_G1_SEL_LSB +: GRP_W];
                    g2_sel <= wb_dat_i[GATE_G2_SEL_LSB +: GRP_W];
                end
                if (wb_sel_i[1]) begin
                    g1_and <= wb_dat_i[GATE_G1_AND_BIT];
                    g2_and <= wb_dat_i[GATE_G2_AND_BIT];
                    // Code 3 is unused and falls back to disconnected
                    case (wb_dat_i[GATE_RANGE_LSB +: 2])
                        2'h1: range_mode <= RNG_IN;
                        2'h2: range_mode <= RNG_OUT;
                        default: range_mode <= RNG_OFF;
                    endcase
                end
            end
        end
    end

    // Pattern recognizer values and care masks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_PAT; i++) begin
                pat_cfg[i] <= PAT_RST;
            end
        end else if (wb_wr && in_bank(wb_adr_i, OFF_PAT_BASE)) begin
            pat_cfg[wb_adr_i[4:2]] <= merge(pat_cfg[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
        end
    end

    // Level table, level count, trigger level and edit commands
    always_ff @(posedge clk_i) begin
        logic [3:0] n;
        logic [3:0] p;
        logic [LVL_W-1:0] at;
        level_cfg_t lw;
        n = 4'h0;
        p = 4'h0;
        at = wb_dat_i[CMD_AT_LSB +: LVL_W];
        lw = '0;
        if (rst_i) begin
            for (int i = 0; i < NUM_LVL; i++) begin
                lvl_cfg[i] <= LVL_NEW_DEFAULT;
            end
            lvl_cfg[0] <= LVL_TRIG_DEFAULT;
            lvl_cfg[1] <= LVL_STORE_DEFAULT;
            num_lvl <= NUM_LVL_RST;
            trig_lvl <= TRIG_LVL_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == OFF_LEVELS && wb_sel_i[0] && wb_sel_i[1]) begin
                n = clamp_num(wb_dat_i[LEVELS_NUM_LSB +: 4]);
                num_lvl <= n;
                if ({1'b0, wb_dat_i[LEVELS_TRIG_LSB +: LVL_W]} > n - 4'h2) begin
                    trig_lvl <= 3'(n - 4'h2);
                end else begin
                    trig_lvl <= wb_dat_i[LEVELS_TRIG_LSB +: LVL_W];
                end
            end
            if (in_bank(wb_adr_i, OFF_LVL_BASE)) begin
                lw = merge(lvl_cfg[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
                lw.rsv0 = 3'h0;
                lw.rsv1 = 3'h0;
                if (lw.occ == 16'h0000) begin
                    lw.occ = 16'h0001;
                end
                lvl_cfg[wb_adr_i[4:2]] <= lw;
            end
            if (wb_adr_i == OFF_CMD && wb_sel_i[0] && {1'b0, at} < num_lvl) begin
                p = (wb_dat_i[CMD_OP_LSB +: 2] == CMD_INS_AFTER) ? {1'b0, at} + 4'h1
                                                                  : {1'b0, at};
                if ((wb_dat_i[CMD_OP_LSB +: 2] == CMD_INS_BEFORE ||
                     wb_dat_i[CMD_OP_LSB +: 2] == CMD_INS_AFTER) &&
                    num_lvl < NUM_LVL_MAX) begin
                    for (int i = 1; i < NUM_LVL; i++) begin
                        if (i > int'(p)) begin
                            lvl_cfg[i] <= lvl_cfg[i-1];
                        end
                    end
                    lvl_cfg[p[2:0]] <= LVL_NEW_DEFAULT;
                    num_lvl <= num_lvl + 4'h1;
                    if ({1'b0, trig_lvl} >= p) begin
                        trig_lvl <= trig_lvl + 3'h1;
                    end
                end else if (wb_dat_i[CMD_OP_LSB +: 2] == CMD_DELETE) begin
                    if (num_lvl == NUM_LVL_MIN || at == trig_lvl || at == last_lvl) begin
                        // These levels always exist; only their terms go back
                        lvl_cfg[at] <= (at == trig_lvl) ? LVL_TRIG_DEFAULT
                                                        : LVL_STORE_DEFAULT;
                    end else begin
                        for (int i = 0; i < NUM_LVL - 1; i++) begin
                            if (i >= int'(at)) begin
                                lvl_cfg[i] <= lvl_cfg[i+1];
                            end
                        end
                        lvl_cfg[NUM_LVL-1] <= LVL_NEW_DEFAULT;
                        num_lvl <= num_lvl - 4'h1;
                        if (trig_lvl > at) begin
                            trig_lvl <= trig_lvl - 3'h1;
                        end
                    end
                end
            end
        end
    end

    // Sequencer state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_state <= SEQ_IDLE;
            cur_lvl <= '0;
            occ_cnt <= '0;
            triggered <= 1'b0;
        end else if (wb_wr && wb_adr_i == OFF_CTRL && wb_sel_i[0]) begin
            // Any run write restarts from level 0
            seq_state <= wb_dat_i[CTRL_RUN_BIT] ? SEQ_RUN : SEQ_IDLE;
            cur_lvl <= '0;
            occ_cnt <= '0;
            triggered <= 1'b0;
        end else if (advance) begin
            cur_lvl <= cur_lvl + 3'h1;
            occ_cnt <= '0;
            if (cur_lvl == trig_lvl) begin
                triggered <= 1'b1;
            end
        end else if (seq_state == SEQ_RUN && sample_i.valid && cur_lvl < last_lvl
                     && branch_hit) begin
            occ_cnt <= occ_cnt + 16'h1;
        end
    end

    // Registered outputs toward acquisition memory
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            store_o <= 1'b0;
            store_data_o <= '0;
            trigger_o <= 1'b0;
            level_o <= '0;
            running_o <= 1'b0;
        end else begin
            store_o <= (seq_state == SEQ_RUN) && sample_i.valid && store_hit;
            store_data_o <= sample_i.data;
            trigger_o <= advance && (cur_lvl == trig_lvl);
            level_o <= cur_lvl;
            running_o <= (seq_state == SEQ_RUN);
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (in_bank(wb_adr_i, OFF_PAT_BASE)) begin
            rd_data = pat_cfg[wb_adr_i[4:2]];
        end else if (in_bank(wb_adr_i, OFF_LVL_BASE)) begin
            rd_data = lvl_cfg[wb_adr_i[4:2]];
        end else begin
            case (wb_adr_i)
                OFF_CTRL: begin
                    rd_data[CTRL_RUN_BIT] = (seq_state == SEQ_RUN);
                    rd_data[CTRL_DUAL_BIT] = dual_mode;
                    rd_data[CTRL_SECOND_BIT] = second_owner;
                end
                OFF_STATUS: begin
                    rd_data[ST_LVL_LSB +: LVL_W] = cur_lvl;
                    rd_data[ST_TRIG_BIT] = triggered;
                    rd_data[ST_LAST_BIT] = (cur_lvl >= last_lvl);
                    rd_data[ST_RUN_BIT] = (seq_state == SEQ_RUN);
                end
                OFF_RANGE_LO: rd_data[LABEL_W-1:0] = range_lo;
                OFF_RANGE_HI: rd_data[LABEL_W-1:0] = range_hi;
                OFF_GATE: begin
                    rd_data[GATE_G1_SEL_LSB +: GRP_W] = g1_sel;
                    rd_data[GATE_G2_SEL_LSB +: GRP_W] = g2_sel;
                    rd_data[GATE_G1_AND_BIT] = g1_and;
                    rd_data[GATE_G2_AND_BIT] = g2_and;
                    rd_data[GATE_RANGE_LSB +: 2] = range_mode;
                end
                OFF_LEVELS: begin
                    rd_data[LEVELS_NUM_LSB +: 4] = num_lvl;
                    rd_data[LEVELS_TRIG_LSB +: LVL_W] = trig_lvl;
                end
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    // Every access is acked one cycle later; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule

// [verification/trig_seq_sva.sv]
// Port-level checker for the state trigger sequencer.
// Assumes a bind from the bench onto the top module; one clock domain.
`timescale 1ns/1ps
module trig_seq_sva
    import trig_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input trig_seq_pkg::sample_t sample_i,
    input wire logic store_o,
    input wire logic [trig_seq_pkg::LABEL_W-1:0] store_data_o,
    input wire logic trigger_o,
    input wire logic [trig_seq_pkg::LVL_W-1:0] level_o,
    input wire logic running_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack wider than one cycle");
    property p_ack_req; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
    a_ack_req: assert property (p_ack_req) else $error("request not acked next cycle");
    property p_rdat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
    a_rdat_hold: assert property (p_rdat_hold) else $error("read data moved without ack");
    property p_store_cause; store_o |-> $past(sample_i.valid); endproperty
    a_store_cause: assert property (p_store_cause) else $error("store without sample");
    property p_store_data; store_o |-> store_data_o == $past(sample_i.data); endproperty
    a_store_data: assert property (p_store_data) else $error("stored data wrong");
    property p_trig_one; trigger_o |=> !trigger_o; endproperty
    a_trig_one: assert property (p_trig_one) else $error("trigger held");
    property p_trig_adv; trigger_o |=> level_o == $past(level_o) + 3'h1; endproperty
    a_trig_adv: assert property (p_trig_adv) else $error("no advance on trigger");
    property p_run_start; $rose(running_o) |-> level_o == 3'h0; endproperty
    a_run_start: assert property (p_run_start) else $error("run not at level 0");
endmodule

// [verification/target_bus_model.sv]
// Behavioural model of the probed target bus, one state per clock at most.
// Assumes the bench queues states through send; gap paces them out.
`timescale 1ns/1ps
module target_bus_model
    import trig_seq_pkg::*;
(
    input wire logic clk_i,
    output trig_seq_pkg::sample_t sample_o
);
    logic [15:0] pend [$];
    int gap = 0;
    int idle = 0;
    initial sample_o = '0;
    task automatic send(input logic [15:0] d);
        pend.push_back(d);
    endtask
    // Idle data flips every idle cycle, alternating between the inverse of the last state and the state itself
    always @(posedge clk_i) begin
        if (pend.size() != 0 && idle >= gap) begin
            sample_o <= {1'b1, pend.pop_front()};
            idle <= 0;
        end else begin
            sample_o <= {1'b0, ~sample_o.data};
            idle <= idle + 1;
        end
    end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the state trigger sequencer.
// Assumes the checker and target bus model are compiled before it.
`timescale 1ns/1ps
bind state_trigger_sequencer trig_seq_sva trig_seq_sva_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_i(sample_i), .store_o(store_o), .store_data_o(store_data_o),
    .trigger_o(trigger_o), .level_o(level_o), .running_o(running_o));
module tb_top;
    import trig_seq_pkg::*;
    typedef struct packed {
        logic [3:0] m;
        logic [11:0] gate;
        logic [7:0] q;
        logic [15:0] d;
        logic [3:0] e;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, trig, store, run;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [2:0] lvl;
    sample_t smp_s;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    // Mode nibble: run, dual, second; expect is trigger on the first sample
    row_t rows [27] = '{44'h1_000_02_12ab_1, 44'h1_000_02_13ab_0, 44'h1_000_0a_13ab_1,
        44'h1_000_00_0000_1, 44'h1_000_01_12ab_0, 44'h1_000_12_0100_1, 44'h1_000_12_01ff_1,
        44'h1_000_12_0200_0, 44'h1_000_12_00ff_0, 44'h1_000_13_0200_1, 44'h1_000_06_0034_1,
        44'h1_000_1f_0000_0, 44'h1_001_14_12ab_1, 44'h1_001_14_0034_0, 44'h1_010_14_0034_1,
        44'h1_101_14_12ab_0, 44'h1_101_14_13ab_1, 44'h1_210_14_0034_0, 44'h1_210_14_12ab_1,
        44'h1_400_14_0150_1, 44'h1_800_14_0150_0, 44'h1_000_14_12ab_0, 44'h3_011_14_0034_0,
        44'h7_011_14_0034_1, 44'h7_000_02_12ab_0, 44'h3_000_06_0034_0, 44'h7_000_12_0150_0};
    initial forever #12.5 clk = ~clk;
    state_trigger_sequencer state_trigger_sequencer_i (.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sample_i(smp_s), .store_o(store),
        .store_data_o(), .trigger_o(trig), .level_o(lvl), .running_o(run));
    target_bus_model target_bus_model_i (.clk_i(clk), .sample_o(smp_s));
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        // No local limit: a slave that never answers runs into the bench timeout
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        wb(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask
    // Window is wide enough for a slow far side
    task automatic smp(input logic [15:0] d, output logic got);
        int t;
        #1;
        target_bus_model_i.send(d);
        got = 1'b0;
        for (t = 0; t < 8 && !got; t++) begin
            @(posedge clk);
            #1;
            got = (store === 1'b1);
        end
    endtask
    initial begin
        logic g;
        int i;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wr(OFF_PAT_BASE, 32'hff00_1200);
        wr(OFF_PAT_BASE + 8'h10, 32'h00ff_0034);
        wr(OFF_RANGE_LO, 32'h0000_0100);
        wr(OFF_RANGE_HI, 32'h0000_01ff);
        foreach (rows[k]) begin
            wr(OFF_GATE, {20'h0, rows[k].gate});
            wr(OFF_LVL_BASE, {16'h0001, rows[k].q, 8'h00});
            wr(OFF_CTRL, {28'h0, rows[k].m});
            smp(rows[k].d, g);
            chk(32'(trig), 32'(rows[k].e[0]));
            chk({30'h0, g, trig}, {30'h0, 1'b1, rows[k].e[0]});
        end
        $display("qualifier table done");
        target_bus_model_i.gap = 2;
        wr(OFF_LVL_BASE, 32'h0003_0202);
        wr(OFF_CTRL, 32'h0000_0001);
        for (i = 0; i < 4; i++) begin
            smp((i == 2) ? 16'h13ab : 16'h12ab, g);
            chk({30'h0, g, trig}, {30'h0, i != 2, i == 3});
        end
        rdc(OFF_STATUS, 32'h0000_0039);
        $display("occurrence done");
        wr(OFF_LEVELS, 32'h0000_0001);
        rdc(OFF_LEVELS, 32'h0000_0002);
        wr(OFF_LEVELS, 32'h0000_070f);
        rdc(OFF_LEVELS, 32'h0000_0608);
        wr(OFF_CMD, 32'h0000_0002);
        rdc(OFF_LEVELS, 32'h0000_0608);
        wr(OFF_CMD, 32'h0000_0033);
        rdc(OFF_LEVELS, 32'h0000_0507);
        wr(OFF_CMD, 32'h0000_0001);
        rdc(OFF_LEVELS, 32'h0000_0608);
        wr(OFF_LVL_BASE + 8'h18, 32'h0005_0303);
        wr(OFF_CMD, 32'h0000_0063);
        rdc(OFF_LEVELS, 32'h0000_0608);
        rdc(OFF_LVL_BASE + 8'h18, 32'h0001_0200);
        $display("level table done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk({28'h0, run, lvl}, 32'h0);
        rdc(OFF_LEVELS, 32'h0000_0002);
        rdc(OFF_LVL_BASE, 32'h0001_0200);
        rdc(OFF_LVL_BASE + 8'h04, 32'h0001_0100);
        rdc(8'h1c, 32'h0);
        wr(OFF_CTRL, 32'h0000_0001);
        smp(16'hbeef, g);
        chk({30'h0, g, trig}, 32'h3);
        $display("reset done");
        results();
    end
endmodule
